// File: inc/cfg_load_pkg.sv
package cfg_load_pkg;
    // configuration word addresses holding the per-port setup words
    localparam logic [7:0] WADDR_PORT1 = 8'h62;
    localparam logic [7:0] WADDR_PORT2 = 8'h64;
    // configuration-space register offsets in each port
    localparam logic [11:0] OFS_PM_CAP = 12'h040;
    localparam logic [11:0] OFS_SLOT_CAP = 12'h0C0;
    localparam logic [11:0] OFS_PORT_NUM = 12'h0CC;
    localparam logic [11:0] OFS_SLOT_CLK = 12'h0D0;
    localparam logic [11:0] OFS_LPVC = 12'h144;
    localparam logic [11:0] OFS_TC_MAP = 12'h154;
    // source bit positions in the configuration word
    localparam int SRC_SLOT_IMPL = 0;
    localparam int SRC_SLOT_CLK = 1;
    localparam int SRC_DSI = 2;
    localparam int SRC_LPVC = 3;
    localparam int SRC_PNUM_LO = 4;
    localparam int SRC_PNUM_HI = 6;
    localparam int SRC_TC_LO = 9;
    localparam int SRC_TC_HI = 15;
    // destination bit positions in the registers
    localparam int DST_SLOT_IMPL = 24;
    localparam int DST_SLOT_CLK = 28;
    localparam int DST_DSI = 21;
    localparam int DST_LPVC = 4;
    localparam int DST_PNUM_LO = 24;
    localparam int DST_PNUM_HI = 26;
    localparam int DST_TC_LO = 1;
    localparam int DST_TC_HI = 7;
    // reset defaults of the loaded fields
    localparam logic RST_FLAG = 1'b0;
    localparam logic [2:0] RST_PNUM = 3'h0;
    localparam logic [6:0] RST_TC_MAP = 7'h00;
    // fields of one port after loading
    typedef struct packed {
        logic slot_impl;
        logic slot_clk;
        logic dsi;
        logic lpvc;
        logic [2:0] pnum;
        logic [6:0] tc_map;
    } port_fields_t;
    localparam port_fields_t RST_FIELDS = '{RST_FLAG, RST_FLAG, RST_FLAG, RST_FLAG,
                                            RST_PNUM, RST_TC_MAP};
    // loader sequence
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_RUN = 2'b01,
        LD_DONE = 2'b11
    } load_state_t;
endpackage

// File: inc/word_if.sv
// one configuration word presented to a port field decoder
interface word_if;
    logic valid; // word strobe
    logic [15:0] data; // word contents
    logic slot_ok; // port owns a slot implemented bit
    modport src (output valid, output data, output slot_ok);
    modport dst (input valid, input data, input slot_ok);
endinterface

// File: hdl/port_field_reg.sv
// holds the loaded fields of one port and updates them from a word
module port_field_reg
    import cfg_load_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic rst_n, // synchronous reset, active low
    word_if.dst w, // word from the loader
    output cfg_load_pkg::port_fields_t fields // registered fields
);
    import cfg_load_pkg::*;
    port_fields_t fields_r; // stored fields
    port_fields_t fields_nxt; // next fields

    // copy the word bits into their destination fields on a strobe
    always_comb begin
        fields_nxt = fields_r;
        if (w.valid) begin
            // slot implemented exists only for the port that has the bit
            if (w.slot_ok) begin
                fields_nxt.slot_impl = w.data[SRC_SLOT_IMPL];
            end
            fields_nxt.slot_clk = w.data[SRC_SLOT_CLK];
            fields_nxt.dsi = w.data[SRC_DSI];
            fields_nxt.lpvc = w.data[SRC_LPVC];
            fields_nxt.pnum = w.data[SRC_PNUM_HI:SRC_PNUM_LO];
            fields_nxt.tc_map = w.data[SRC_TC_HI:SRC_TC_LO];
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fields_r <= RST_FIELDS;
        end else begin
            fields_r <= fields_nxt;
        end
    end

    assign fields = fields_r;

    a_tc_copy: assert property (@(posedge clk) disable iff (!rst_n)
        w.valid |=> fields_r.tc_map == $past(w.data[15:9]))
        else $error("tc map not copied");
    a_pnum_copy: assert property (@(posedge clk) disable iff (!rst_n)
        w.valid |=> fields_r.pnum == $past(w.data[6:4]))
        else $error("port number not copied");
    a_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !w.valid |=> $stable(fields_r))
        else $error("fields changed without a word");
endmodule

// File: hdl/eeprom_port_config_loader.sv
// How it works
// - word 64h bit0 sets port2 slot implemented
// - word bit1 loads slot clock config bit
// - word bit2 loads device specific init bit
// - word bit3 allocates VC1 as low priority
// - word bits 6:4 give logical port number
// - word bits 15:9 form traffic-class mask
// - mask lands in map register bits 7:1
module eeprom_port_config_loader
    import cfg_load_pkg::*;
(
    input wire logic clk, // core clock, 50 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic mem_valid, // configuration memory found and checked
    input wire logic word_valid, // one-cycle strobe of a word read
    input wire logic [7:0] word_addr, // address of the word read
    input wire logic [15:0] word_data, // contents of the word read
    input wire logic load_end, // memory reader has finished its pass
    input wire logic [1:0] rd_port, // port selected for a register read
    input wire logic [11:0] rd_ofs, // register offset for a read
    output logic [31:0] rd_data, // loaded bits of the selected register
    output logic load_done, // loader finished, host requests may pass
    output logic [7:0] p1_tc_map, // port 1 map register low byte
    output logic [7:0] p2_tc_map // port 2 map register low byte
);
    import cfg_load_pkg::*;

    load_state_t state_r; // loader state
    load_state_t state_nxt; // next loader state
    logic [31:0] rd_data_r; // registered read data
    logic [31:0] rd_data_nxt; // next read data
    port_fields_t f1; // port 1 fields
    port_fields_t f2; // port 2 fields
    port_fields_t fs; // fields of the selected port
    logic accept; // a word may be taken now

    word_if w1 ();
    word_if w2 ();

    // words are taken only while running and only from a valid memory
    assign accept = (state_r == LD_RUN) && mem_valid && word_valid;
    // port 1's word address is an assumed package constant; change it there
    assign w1.valid = accept && (word_addr == WADDR_PORT1);
    assign w1.data = word_data;
    assign w1.slot_ok = 1'b0; // port 1 has no slot bit in its word
    assign w2.valid = accept && (word_addr == WADDR_PORT2);
    assign w2.data = word_data;
    assign w2.slot_ok = 1'b1;

    // one field store per port; each acts only on its own strobe
    port_field_reg u_p1 (
        .clk(clk),
        .rst_n(rst_n),
        .w(w1),
        .fields(f1)
    );
    port_field_reg u_p2 (
        .clk(clk),
        .rst_n(rst_n),
        .w(w2),
        .fields(f2)
    );

    // sequence: start after reset, end when the reader ends its pass
    // a pass runs once; a new one needs a reset
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LD_IDLE: begin
                // reset is over: words may come from the next edge
                state_nxt = LD_RUN;
            end
            LD_RUN: begin
                // no valid memory means nothing to wait for: defaults stay
                if (load_end || !mem_valid) begin
                    state_nxt = LD_DONE;
                end
            end
            LD_DONE: begin
                // only a reset opens a new pass; late words stay out
                state_nxt = LD_DONE;
            end
            default: begin
                // the spare code never holds: restart the pass
                state_nxt = LD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= LD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // host gating signal; combinational so it rises with the state
    assign load_done = (state_r == LD_DONE);

    // pick the port whose fields are read; port 0 is outside this block
    always_comb begin
        case (rd_port)
            2'h1: fs = f1;
            2'h2: fs = f2;
            default: fs = RST_FIELDS;
        endcase
    end

    // assemble the loaded bits at their documented positions
    // unmapped offsets read zero, so a host probe sees no stray bits
    always_comb begin
        rd_data_nxt = 32'h0000_0000;
        case (rd_ofs)
            OFS_SLOT_CAP: rd_data_nxt[DST_SLOT_IMPL] = fs.slot_impl;
            OFS_SLOT_CLK: rd_data_nxt[DST_SLOT_CLK] = fs.slot_clk;
            OFS_PM_CAP: rd_data_nxt[DST_DSI] = fs.dsi;
            OFS_LPVC: rd_data_nxt[DST_LPVC] = fs.lpvc;
            OFS_PORT_NUM: rd_data_nxt[DST_PNUM_HI:DST_PNUM_LO] = fs.pnum;
            OFS_TC_MAP: rd_data_nxt[DST_TC_HI:DST_TC_LO] = fs.tc_map;
            default: rd_data_nxt = 32'h0000_0000;
        endcase
    end

    // one cycle of read latency keeps the offset decode off the host path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_r <= 32'h0000_0000;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    // bit 0 of the map register is VC0's own TC0, not loaded here
    assign p1_tc_map = {f1.tc_map, 1'b0};
    assign p2_tc_map = {f2.tc_map, 1'b0};

    // a taken word lands in its port's store one edge later
    a_slot_p2: assert property (@(posedge clk) disable iff (!rst_n)
        w2.valid |=> f2.slot_impl == $past(word_data[0]))
        else $error("slot bit of port 2 not loaded");
    a_slot_p1: assert property (@(posedge clk) disable iff (!rst_n)
        $stable(f1.slot_impl))
        else $error("port 1 slot bit changed");
    a_clk_bit: assert property (@(posedge clk) disable iff (!rst_n)
        w1.valid |=> f1.slot_clk == $past(word_data[1]))
        else $error("slot clock bit not loaded");
    a_clk_p2: assert property (@(posedge clk) disable iff (!rst_n)
        w2.valid |=> f2.slot_clk == $past(word_data[SRC_SLOT_CLK]))
        else $error("port 2 slot clock bit not loaded");
    a_dsi_bit: assert property (@(posedge clk) disable iff (!rst_n)
        w2.valid |=> f2.dsi == $past(word_data[2]))
        else $error("init bit not loaded");
    a_dsi_p1: assert property (@(posedge clk) disable iff (!rst_n)
        w1.valid |=> f1.dsi == $past(word_data[SRC_DSI]))
        else $error("port 1 init bit not loaded");
    a_lpvc_bit: assert property (@(posedge clk) disable iff (!rst_n)
        w1.valid |=> f1.lpvc == $past(word_data[3]))
        else $error("lpvc bit not loaded");
    a_lpvc_p2: assert property (@(posedge clk) disable iff (!rst_n)
        w2.valid |=> f2.lpvc == $past(word_data[SRC_LPVC]))
        else $error("port 2 lpvc bit not loaded");

    // the map bytes follow the stored mask, bit 0 is never loaded
    a_tc_out1: assert property (@(posedge clk) disable iff (!rst_n)
        w1.valid |=> p1_tc_map[7:1] == $past(word_data[SRC_TC_HI:SRC_TC_LO]))
        else $error("port 1 map byte not loaded");
    a_tc_out2: assert property (@(posedge clk) disable iff (!rst_n)
        w2.valid |=> p2_tc_map[7:1] == $past(word_data[SRC_TC_HI:SRC_TC_LO]))
        else $error("port 2 map byte not loaded");
    a_tc_low: assert property (@(posedge clk) disable iff (!rst_n)
        p1_tc_map[0] == 1'b0 && p2_tc_map[0] == 1'b0)
        else $error("map byte bit 0 set");

    // reads show the stored bits one edge later, at their register positions
    a_slot_place: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_port == 2'h2 && rd_ofs == OFS_SLOT_CAP) |=>
        rd_data[DST_SLOT_IMPL] == $past(f2.slot_impl))
        else $error("slot bit misplaced");
    a_slot_none1: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_port == 2'h1 && rd_ofs == OFS_SLOT_CAP) |=> !rd_data[DST_SLOT_IMPL])
        else $error("port 1 slot bit read as set");
    a_clk_place: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_port == 2'h1 && rd_ofs == OFS_SLOT_CLK) |=>
        rd_data[DST_SLOT_CLK] == $past(f1.slot_clk))
        else $error("slot clock bit misplaced");
    a_dsi_place: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_port == 2'h1 && rd_ofs == OFS_PM_CAP) |=>
        rd_data[DST_DSI] == $past(f1.dsi))
        else $error("init bit misplaced");
    a_lpvc_place: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_port == 2'h2 && rd_ofs == OFS_LPVC) |=>
        rd_data[DST_LPVC] == $past(f2.lpvc))
        else $error("lpvc bit misplaced");
    a_pnum_place: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_port == 2'h1 && rd_ofs == OFS_PORT_NUM) |=>
        rd_data[DST_PNUM_HI:DST_PNUM_LO] == $past(f1.pnum))
        else $error("port number misplaced");
    a_map_place: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_port == 2'h2 && rd_ofs == OFS_TC_MAP) |=>
        rd_data[DST_TC_HI:DST_TC_LO] == $past(f2.tc_map))
        else $error("map read misplaced");

    // one pass after reset, and no word taken outside it
    a_idle_run: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == LD_IDLE |=> state_r == LD_RUN)
        else $error("pass did not start after reset");
    a_early_refuse: assert property (@(posedge clk) disable iff (!rst_n)
        state_r != LD_RUN |-> !w1.valid && !w2.valid)
        else $error("word taken outside the pass");
    a_no_late: assert property (@(posedge clk) disable iff (!rst_n)
        load_done |=> !w1.valid && !w2.valid)
        else $error("word taken after done");
    a_bad_mem: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == LD_RUN && !mem_valid) |=> load_done)
        else $error("loader stuck without memory");
    a_done_hold: assert property (@(posedge clk) disable iff (!rst_n)
        load_done |=> load_done)
        else $error("done dropped before reset");

    // main scenarios to be seen at least once
    c_load_p2: cover property (@(posedge clk) disable iff (!rst_n) w2.valid);
    c_load_p1: cover property (@(posedge clk) disable iff (!rst_n) w1.valid);
    c_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(load_done));
    c_map_read: cover property (@(posedge clk) disable iff (!rst_n)
        rd_port == 2'h2 && rd_ofs == OFS_TC_MAP);
    c_mem_lost: cover property (@(posedge clk) disable iff (!rst_n)
        state_r == LD_RUN && !mem_valid);
endmodule

// File: bench/cfg_mem_model.sv
// configuration memory reader stand-in: presents one word per strobe
module cfg_mem_model (
    input wire logic clk, // core clock
    input wire logic req, // bench asks for a word this cycle
    input wire logic [7:0] req_addr, // address to present
    input wire logic [15:0] req_data, // contents to present
    output logic word_valid, // word strobe towards the loader
    output logic [7:0] word_addr, // presented address
    output logic [15:0] word_data // presented contents
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_addr; // last address handed over
    logic [15:0] last_data; // last contents handed over
    initial begin
        last_addr = 8'h00;
        last_data = 16'h0000;
    end
    // remember what was handed over so idle lines can show its inverse
    always @(posedge clk) begin
        if (req) begin
            last_addr <= req_addr;
            last_data <= req_data;
        end
    end
    // outside a strobe the lines carry no stale copy of the last word
    assign word_valid = req;
    assign word_addr = req ? req_addr : ~last_addr;
    assign word_data = req ? req_data : ~last_data;
endmodule

// File: bench/eeprom_port_config_loader_tb_top.sv
// self-checking bench for the per-port configuration loader
module eeprom_port_config_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cfg_load_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, mem_valid = 1'b1, load_end = 1'b0; // bench-driven
    logic req = 1'b0; // word request to the memory model
    logic [7:0] req_addr = 8'h00; // requested address
    logic [15:0] req_data = 16'h0000; // requested contents
    logic [1:0] rd_port = 2'h0; // register read port
    logic [11:0] rd_ofs = 12'h000; // register read offset
    logic word_valid, load_done; // design-facing strobes
    logic [7:0] word_addr, p1_tc_map, p2_tc_map; // address and map bytes
    logic [15:0] word_data; // word contents
    logic [31:0] rd_data; // read result
    int miscompares = 0, checks_done = 0; // tallies
    // offsets swept on every port check; the last one is unmapped
    logic [11:0] ofs_list [7] = '{OFS_PM_CAP, OFS_SLOT_CAP, OFS_PORT_NUM, OFS_SLOT_CLK,
                                  OFS_LPVC, OFS_TC_MAP, 12'h0FF};
    initial begin
        forever #10 clk = ~clk;
    end
    cfg_mem_model i_mem (.clk(clk), .req(req), .req_addr(req_addr), .req_data(req_data),
        .word_valid(word_valid), .word_addr(word_addr), .word_data(word_data));
    eeprom_port_config_loader i_dut (.clk(clk), .rst_n(rst_n), .mem_valid(mem_valid),
        .word_valid(word_valid), .word_addr(word_addr), .word_data(word_data),
        .load_end(load_end), .rd_port(rd_port), .rd_ofs(rd_ofs), .rd_data(rd_data),
        .load_done(load_done), .p1_tc_map(p1_tc_map), .p2_tc_map(p2_tc_map));
    // expected register image built from the documented bit moves
    function automatic logic [31:0] exp_reg(input logic [1:0] p, input logic [11:0] o,
                                            input logic [15:0] w);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (o == OFS_SLOT_CAP && p == 2'h2) r[24] = w[0];
        if (o == OFS_SLOT_CLK) r[28] = w[1];
        if (o == OFS_PM_CAP) r[21] = w[2];
        if (o == OFS_LPVC) r[4] = w[3];
        if (o == OFS_PORT_NUM) r[26:24] = w[6:4];
        if (o == OFS_TC_MAP) r[7:1] = w[15:9];
        if (p != 2'h1 && p != 2'h2) r = 32'h0000_0000; // other ports read zero
        return r;
    endfunction
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // read every offset of a port and compare against the word image
    task automatic check_port(input logic [1:0] p, input logic [15:0] w);
        string s;
        logic [31:0] e;
        for (int i = 0; i < 7; i++) begin
            @(negedge clk);
            rd_port = p;
            rd_ofs = ofs_list[i];
            @(negedge clk);
            s = $sformatf("port%0d reg %h", p, ofs_list[i]);
            e = exp_reg(p, ofs_list[i], w);
            compare(s, e, rd_data);
        end
    endtask
    // strobe stays up between back-to-back words; word_idle drops it
    task automatic send_word(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        req = 1'b1;
        req_addr = a;
        req_data = d;
    endtask
    task automatic word_idle();
        @(negedge clk);
        req = 1'b0;
    endtask
    task automatic do_reset(input logic mv);
        @(negedge clk);
        rst_n = 1'b0;
        mem_valid = mv;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    // pulse load_end and wait a bounded time for load_done
    task automatic finish_load();
        int n;
        @(negedge clk);
        load_end = 1'b1;
        @(negedge clk);
        load_end = 1'b0;
        n = 0;
        while (load_done !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        compare("load_done", 32'h1, {31'h0, load_done});
    endtask
    task automatic test_defaults();
        compare("load_done in run", 32'h0, {31'h0, load_done});
        check_port(2'h1, 16'h0000);
        check_port(2'h2, 16'h0000);
        $display("test defaults done");
    endtask
    // back-to-back words for both ports plus an ignored address
    task automatic test_load();
        send_word(WADDR_PORT2, 16'hAAD5);
        send_word(WADDR_PORT1, 16'h552B);
        send_word(8'h63, 16'hFFFF);
        word_idle();
        check_port(2'h2, 16'hAAD5);
        check_port(2'h1, 16'h552B);
        check_port(2'h3, 16'hFFFF);
        compare("p1_tc_map", {24'h0, 7'h2A, 1'b0}, {24'h0, p1_tc_map});
        compare("p2_tc_map", {24'h0, 7'h55, 1'b0}, {24'h0, p2_tc_map});
        send_word(WADDR_PORT2, 16'h5B6E);
        word_idle();
        check_port(2'h2, 16'h5B6E);
        $display("test load done");
    endtask
    // after the pass has ended no word may touch the registers
    task automatic test_after_done();
        finish_load();
        send_word(WADDR_PORT2, 16'hFFFF);
        word_idle();
        check_port(2'h2, 16'h5B6E);
        $display("test after done done");
    endtask
    // without a valid memory the fields keep their defaults
    task automatic test_no_mem();
        // memory lost in the very cycle a word is offered: the word is refused
        do_reset(1'b1);
        send_word(WADDR_PORT2, 16'hFFFF);
        mem_valid = 1'b0;
        word_idle();
        check_port(2'h2, 16'h0000);
        compare("load_done mem lost", 32'h1, {31'h0, load_done});
        do_reset(1'b0);
        send_word(WADDR_PORT2, 16'hFFFF);
        send_word(WADDR_PORT1, 16'hFFFF);
        word_idle();
        check_port(2'h2, 16'h0000);
        check_port(2'h1, 16'h0000);
        finish_load();
        $display("test no memory done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        do_reset(1'b1);
        test_defaults();
        test_load();
        test_after_done();
        test_no_mem();
        close_out();
    end
endmodule
